/* src/bcw_pkg.sv */
// Shared constants, types and functions for the burst-chop-4 write CRC link.
// Assumes both ends run on one clock and import nothing; use bcw_pkg::name.
package bcw_pkg;

  // Burst shape
  localparam int unsigned BEATS = 10;
  localparam int unsigned DATA_BEATS = 4;
  localparam logic [3:0] BEAT_LAST_DATA = 4'h3;
  localparam logic [3:0] BEAT_CRC = 4'h8;
  localparam logic [3:0] BEAT_TAIL = 4'h9;

  // Lane layout: eight DQ lanes plus one mask/inversion lane per tree
  localparam int unsigned LANES_PER_TREE = 8;
  localparam int unsigned TREE_IN_W = 72;
  localparam int unsigned TREES = 2;
  localparam int unsigned DQ_W = 16;
  localparam int unsigned DMI_W = 2;
  localparam int unsigned CRC_W = 8;
  localparam int unsigned REAL_INPUTS = 36;

  // Tree polynomial and start value; serial shift from input 71 down to 0
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;

  typedef logic [TREE_IN_W-1:0] bcw_vec_t;
  typedef logic [CRC_W-1:0] bcw_crc_t;

  // One tree's input vector from 32 data bits (lane n beat k at 4n+k)
  // and four mask/inversion beats; unused positions are ones.
  function automatic bcw_vec_t bcw_build_vec(input logic [31:0] data,
                                             input logic [3:0] dmi,
                                             input logic a2,
                                             input logic dmi_en);
    bcw_vec_t v;
    logic [3:0] nib;
    v = '1;
    for (int n = 0; n < 9; n++) begin
      if (n < 8) begin
        nib = data[4*n +: 4];
      end else begin
        nib = dmi_en ? dmi : 4'hF;
      end
      if (a2) begin
        v[8*n+4 +: 4] = nib;
      end else begin
        v[8*n +: 4] = nib;
      end
    end
    return v;
  endfunction

  function automatic bcw_crc_t bcw_crc8(input bcw_vec_t v);
    bcw_crc_t c;
    logic fb;
    c = CRC_INIT;
    for (int i = TREE_IN_W - 1; i >= 0; i--) begin
      fb = c[7] ^ v[i];
      c = {c[6:0], 1'b0};
      if (fb) begin
        c = c ^ CRC_POLY;
      end
    end
    return c;
  endfunction

endpackage

/* src/bcw_link_if.sv */
// Beat-serial write link between controller and memory device.
// Assumes one shared clock; the bench instantiates and joins both ends.
`timescale 1ns/1ps
`default_nettype none
interface bcw_link_if;
  logic beat_vld;
  logic beat_first;
  logic a2;
  logic [15:0] dq;
  logic [1:0] dmi;

  modport host (output beat_vld, output beat_first, output a2,
                output dq, output dmi);
  modport dram (input beat_vld, input beat_first, input a2,
                input dq, input dmi);
endinterface
`default_nettype wire

/* src/bcw_host.sv */
// Controller end: sends one burst-chop-4 write with CRC per request.
// Assumes the device end samples the link on the same core_clk edge.
`timescale 1ns/1ps
`default_nettype none
module bcw_host (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  input wire logic ce,
  // Configuration
  input wire logic cfg_x16,
  input wire logic cfg_dmi_en,
  // Request
  input wire logic req_vld,
  input wire logic req_a2,
  input wire logic [63:0] req_data,
  input wire logic [7:0] req_dmi,
  input wire logic req_bad_crc,
  output logic req_rdy,
  // Link
  bcw_link_if.host link
);
  typedef enum logic [1:0] {H_IDLE = 2'b00, H_SEND = 2'b01} bcw_hst_t;

  bcw_hst_t st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [63:0] dat_q, dat_d;
  logic [7:0] dmi_q, dmi_d;
  logic [15:0] crc_q, crc_d;
  logic a2_q, a2_d;
  logic x16_q, x16_d;
  logic rdy_q, rdy_d;
  logic vld_q, vld_d, first_q, first_d, la2_q, la2_d;
  logic [15:0] dq_q, dq_d;
  logic [1:0] ldmi_q, ldmi_d;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    dat_d = dat_q;
    dmi_d = dmi_q;
    crc_d = crc_q;
    a2_d = a2_q;
    x16_d = x16_q;
    rdy_d = rdy_q;
    vld_d = 1'b0;
    first_d = 1'b0;
    la2_d = la2_q;
    dq_d = 16'hFFFF;
    ldmi_d = 2'h3;
    case (st_q)
      H_IDLE: begin
        if (req_vld && rdy_q) begin
          st_d = H_SEND;
          cnt_d = 4'h0;
          dat_d = req_data;
          dmi_d = req_dmi;
          a2_d = req_a2;
          x16_d = cfg_x16;
          rdy_d = 1'b0;
          // Sender builds the same tree inputs as the device
          for (int t = 0; t < 2; t++) begin
            crc_d[8*t +: 8] = bcw_pkg::bcw_crc8(bcw_pkg::bcw_build_vec(
              req_data[32*t +: 32], req_dmi[4*t +: 4], req_a2, cfg_dmi_en));
          end
          crc_d[0] = crc_d[0] ^ req_bad_crc;
        end
      end
      H_SEND: begin
        vld_d = 1'b1;
        first_d = (cnt_q == 4'h0);
        la2_d = a2_q;
        if (cnt_q <= bcw_pkg::BEAT_LAST_DATA) begin
          for (int n = 0; n < 16; n++) begin
            dq_d[n] = dat_q[4*n + int'(cnt_q)];
          end
          for (int m = 0; m < 2; m++) begin
            ldmi_d[m] = cfg_dmi_en ? dmi_q[4*m + int'(cnt_q)] : 1'b1;
          end
        end else if (cnt_q == bcw_pkg::BEAT_CRC) begin
          dq_d = x16_q ? crc_q : {8'hFF, crc_q[7:0]};
        end
        // Beats 4..7 and 9 stay all ones, mask lane ones in 8 and 9
        if (cnt_q == bcw_pkg::BEAT_TAIL) begin
          st_d = H_IDLE;
          rdy_d = 1'b1;
        end else begin
          cnt_d = cnt_q + 4'h1;
        end
      end
      default: begin
        st_d = H_IDLE;
        rdy_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_q <= H_IDLE;
      cnt_q <= 4'h0;
      dat_q <= 64'h0;
      dmi_q <= 8'h0;
      crc_q <= 16'h0;
      a2_q <= 1'b0;
      x16_q <= 1'b0;
      rdy_q <= 1'b1;
      vld_q <= 1'b0;
      first_q <= 1'b0;
      la2_q <= 1'b0;
      dq_q <= 16'hFFFF;
      ldmi_q <= 2'h3;
    end else if (ce) begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      dat_q <= dat_d;
      dmi_q <= dmi_d;
      crc_q <= crc_d;
      a2_q <= a2_d;
      x16_q <= x16_d;
      rdy_q <= rdy_d;
      vld_q <= vld_d;
      first_q <= first_d;
      la2_q <= la2_d;
      dq_q <= dq_d;
      ldmi_q <= ldmi_d;
    end
  end

  assign req_rdy = rdy_q;
  assign link.beat_vld = vld_q;
  assign link.beat_first = first_q;
  assign link.a2 = la2_q;
  assign link.dq = dq_q;
  assign link.dmi = ldmi_q;
endmodule // bcw_host
`default_nettype wire

/* src/bcw_dram.sv */
// Device end: gathers a burst-chop-4 write, rebuilds the CRC tree inputs
// and checks them against the CRC carried in beat 8.
// Assumes link signals come from logic on the same core_clk (no sync).
//
// Behaviour
// - Byte tree uses 36 real bits, rest ones
// - A2 low: beats 0-3 feed low nibble
// - Beat 8 carries CRC, beat 9 ones
// - A2 low: mask lane feeds 67:64 if enabled
// - A2 high: beats feed upper nibble positions
// - A2 high: mask lane feeds 71:68 if enabled
// - Word width uses two identical trees
// - Upper lanes feed inputs 72-143, CRC8-15
// - Word, A2 low: upper mask feeds 139:136
// - Word, A2 high: upper mask feeds 143:140
// - Word, A2 high: upper lanes use upper nibbles
// - Fixed chop mode; A2 low picks first half, high the second
// - Lower tree CRC7-0, upper CRC15-8
`timescale 1ns/1ps
`default_nettype none
module bcw_dram #(
  parameter int unsigned TREES_USED = 2
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  input wire logic ce,
  // Configuration
  input wire logic cfg_x16,
  input wire logic cfg_dmi_en,
  // Link
  bcw_link_if.dram link,
  // Received write
  output logic wr_vld,
  output logic wr_a2,
  output logic [63:0] wr_data,
  output logic [7:0] wr_dmi,
  // Check results
  output logic wr_crc_err,
  output logic [1:0] wr_err_tree,
  output logic wr_fmt_err,
  output logic [15:0] calc_crc
);
  // Only one or two byte trees exist
  if (TREES_USED < 1 || TREES_USED > bcw_pkg::TREES) begin : g_bad_cfg
    $error("TREES_USED must be 1 or 2");
  end

  typedef enum logic [1:0] {D_IDLE = 2'b00, D_RECV = 2'b01} bcw_dst_t;

  bcw_dst_t st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic a2_q, a2_d;
  logic x16_q, x16_d;
  logic [63:0] dat_q, dat_d;
  logic [7:0] dmi_q, dmi_d;
  logic [15:0] rcrc_q, rcrc_d;
  logic fmt_q, fmt_d;
  logic vld_q, vld_d;
  logic err_q, err_d;
  logic [1:0] etree_q, etree_d;
  logic ferr_q, ferr_d;
  logic [15:0] calc_q, calc_d;
  logic oa2_q, oa2_d;
  logic [63:0] odat_q, odat_d;
  logic [7:0] odmi_q, odmi_d;
  logic [15:0] tree_crc;
  logic [1:0] tree_bad;
  logic [15:0] dq_use;

  // Unused upper lanes in byte mode read as ones so stray levels are benign
  assign dq_use = x16_q ? link.dq : {8'hFF, link.dq[7:0]};

  // One tree per byte half, built from the same function
  for (genvar t = 0; t < bcw_pkg::TREES; t++) begin : g_tree
    if (t < TREES_USED) begin : g_on
      bcw_pkg::bcw_vec_t vec;
      // Nibble placement by A2 and mask gating
      // Upper half uses inputs 72..143 the same way
      assign vec = bcw_pkg::bcw_build_vec(dat_q[32*t +: 32],
                                          dmi_q[4*t +: 4], a2_q, cfg_dmi_en);
      assign tree_crc[8*t +: 8] = bcw_pkg::bcw_crc8(vec);
      assign tree_bad[t] = (tree_crc[8*t +: 8] != rcrc_q[8*t +: 8]);
    end else begin : g_off
      assign tree_crc[8*t +: 8] = 8'h00;
      assign tree_bad[t] = 1'b0;
    end
  end

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    a2_d = a2_q;
    x16_d = x16_q;
    dat_d = dat_q;
    dmi_d = dmi_q;
    rcrc_d = rcrc_q;
    fmt_d = fmt_q;
    vld_d = 1'b0;
    err_d = 1'b0;
    etree_d = 2'b00;
    ferr_d = 1'b0;
    calc_d = calc_q;
    oa2_d = oa2_q;
    odat_d = odat_q;
    odmi_d = odmi_q;
    // A fresh first beat restarts any partial burst; A2 latched here
    if (link.beat_vld && link.beat_first) begin
      st_d = D_RECV;
      cnt_d = 4'h1;
      a2_d = link.a2;
      x16_d = cfg_x16;
      fmt_d = 1'b0;
      for (int n = 0; n < 16; n++) begin
        dat_d[4*n] = link.dq[n];
      end
      for (int m = 0; m < 2; m++) begin
        dmi_d[4*m] = link.dmi[m];
      end
    end else begin
      case (st_q)
        D_IDLE: begin
          st_d = D_IDLE;
        end
        D_RECV: begin
          if (link.beat_vld) begin
            if (cnt_q <= bcw_pkg::BEAT_LAST_DATA) begin
              for (int n = 0; n < 16; n++) begin
                dat_d[4*n + int'(cnt_q)] = link.dq[n];
              end
              for (int m = 0; m < 2; m++) begin
                dmi_d[4*m + int'(cnt_q)] = link.dmi[m];
              end
            end
            // Beats 4..7 are not looked at: the tree sees ones there
            if (cnt_q == bcw_pkg::BEAT_CRC) begin
              rcrc_d = x16_q ? link.dq : {8'h00, link.dq[7:0]};
              fmt_d = fmt_q | (link.dmi[0] != 1'b1) |
                      (x16_q & (link.dmi[1] != 1'b1));
            end
            if (cnt_q == bcw_pkg::BEAT_TAIL) begin
              // Tail beat must be all ones on every used lane
              ferr_d = fmt_q | (dq_use != 16'hFFFF) | (link.dmi[0] != 1'b1) |
                       (x16_q & (link.dmi[1] != 1'b1));
              etree_d = {tree_bad[1] & x16_q, tree_bad[0]};
              err_d = tree_bad[0] | (tree_bad[1] & x16_q);
              calc_d = x16_q ? tree_crc : {8'h00, tree_crc[7:0]};
              vld_d = 1'b1;
              oa2_d = a2_q;
              odat_d = x16_q ? dat_q : {32'h0, dat_q[31:0]};
              odmi_d = x16_q ? dmi_q : {4'h0, dmi_q[3:0]};
              st_d = D_IDLE;
            end else begin
              cnt_d = cnt_q + 4'h1;
            end
          end
        end
        default: begin
          st_d = D_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_q <= D_IDLE;
      cnt_q <= 4'h0;
      a2_q <= 1'b0;
      x16_q <= 1'b0;
      dat_q <= 64'h0;
      dmi_q <= 8'h0;
      rcrc_q <= 16'h0;
      fmt_q <= 1'b0;
      vld_q <= 1'b0;
      err_q <= 1'b0;
      etree_q <= 2'b00;
      ferr_q <= 1'b0;
      calc_q <= 16'h0;
      oa2_q <= 1'b0;
      odat_q <= 64'h0;
      odmi_q <= 8'h0;
    end else if (ce) begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      a2_q <= a2_d;
      x16_q <= x16_d;
      dat_q <= dat_d;
      dmi_q <= dmi_d;
      rcrc_q <= rcrc_d;
      fmt_q <= fmt_d;
      vld_q <= vld_d;
      err_q <= err_d;
      etree_q <= etree_d;
      ferr_q <= ferr_d;
      calc_q <= calc_d;
      oa2_q <= oa2_d;
      odat_q <= odat_d;
      odmi_q <= odmi_d;
    end
  end

  assign wr_vld = vld_q;
  assign wr_a2 = oa2_q;
  assign wr_data = odat_q;
  assign wr_dmi = odmi_q;
  assign wr_crc_err = err_q;
  assign wr_err_tree = etree_q;
  assign wr_fmt_err = ferr_q;
  assign calc_crc = calc_q;
endmodule // bcw_dram
`default_nettype wire

/* tb/bcw_link_checker.sv */
// Concurrent checks on the joined beat-serial write link.
// Assumes one clock; tb_top instantiates it beside the interface.
`timescale 1ns/1ps
`default_nettype none
module bcw_link_checker (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Link
  input wire logic beat_vld,
  input wire logic beat_first,
  input wire logic a2,
  input wire logic [15:0] dq,
  input wire logic [1:0] dmi
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  logic ones;
  assign ones = (dq == 16'hFFFF) && (dmi == 2'h3);

  AST_FIRST_VLD:
    assert property (beat_first |-> beat_vld)
    else $error("first beat without valid");
  AST_START:
    assert property ($rose(beat_vld) |-> beat_first)
    else $error("burst started without first mark");
  AST_BURST_LEN:
    assert property (beat_first |-> beat_vld[*8] ##1 beat_vld[*2]
      ##1 !beat_vld)
    else $error("burst is not ten beats");
  AST_FIRST_ONCE:
    assert property (beat_first |=> !beat_first[*8] ##1 !beat_first)
    else $error("second first mark inside burst");
  AST_PAD_ONES:
    assert property (beat_first |-> ##4 ones[*4])
    else $error("beats four to seven not all ones");
  AST_CRC_MASK:
    assert property (beat_first |-> ##8 dmi == 2'h3)
    else $error("mask lanes not ones in crc beat");
  AST_TAIL_ONES:
    assert property (beat_first |-> ##9 ones)
    else $error("last beat not all ones");
  AST_A2_HOLD:
    assert property (beat_vld && !beat_first |-> $stable(a2))
    else $error("a2 changed inside burst");
endmodule // bcw_link_checker
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench: host and device joined over the link interface.
// Assumes one 50 MHz clock; expectations are rebuilt here from scratch.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic core_clk, reset, cfg_x16, cfg_dmi_en, req_vld, req_a2, req_bad_crc;
  logic req_rdy, wr_vld, wr_a2, wr_crc_err, wr_fmt_err, ce;
  logic [63:0] req_data, wr_data;
  logic [7:0] req_dmi, wr_dmi;
  logic [1:0] wr_err_tree;
  logic [15:0] calc_crc;
  int n_errors, check_count, cycles;

  bcw_link_if bcw_link_if_inst ();
  // Enable dropped only while idle: a mid-burst freeze stretches the burst
  bcw_host bcw_host_inst (.core_clk(core_clk), .reset(reset), .ce(ce),
    .cfg_x16(cfg_x16), .cfg_dmi_en(cfg_dmi_en), .req_vld(req_vld),
    .req_a2(req_a2), .req_data(req_data), .req_dmi(req_dmi),
    .req_bad_crc(req_bad_crc), .req_rdy(req_rdy), .link(bcw_link_if_inst));
  bcw_dram bcw_dram_inst (.core_clk(core_clk), .reset(reset), .ce(ce),
    .cfg_x16(cfg_x16), .cfg_dmi_en(cfg_dmi_en), .link(bcw_link_if_inst),
    .wr_vld(wr_vld), .wr_a2(wr_a2), .wr_data(wr_data), .wr_dmi(wr_dmi),
    .wr_crc_err(wr_crc_err), .wr_err_tree(wr_err_tree),
    .wr_fmt_err(wr_fmt_err), .calc_crc(calc_crc));
  bcw_link_checker bcw_link_checker_inst (.core_clk(core_clk),
    .reset(reset), .beat_vld(bcw_link_if_inst.beat_vld),
    .beat_first(bcw_link_if_inst.beat_first), .a2(bcw_link_if_inst.a2),
    .dq(bcw_link_if_inst.dq), .dmi(bcw_link_if_inst.dmi));

  function automatic logic [7:0] crc_of(input logic [71:0] v);
    logic [7:0] c;
    c = bcw_pkg::CRC_INIT;
    for (int i = 71; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? bcw_pkg::CRC_POLY : 8'h00);
    return c;
  endfunction

  // Unused nibble of every lane byte stays at ones
  function automatic logic [71:0] vec_of(input logic [31:0] d,
      input logic [3:0] m, input logic hi);
    logic [71:0] v;
    v = '1;
    for (int n = 0; n < 9; n++)
      v[8*n + (hi ? 4 : 0) +: 4] = (n < 8) ? d[4*n +: 4] : m;
    return v;
  endfunction

  task automatic check(input logic [63:0] got, exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic run_write(input logic x16, hi, en, bad, frz,
      input logic [63:0] d, input logic [7:0] m);
    logic [7:0] mg;
    logic [63:0] ed;
    logic [15:0] ec;
    int k;
    mg = en ? m : 8'hFF;
    ed = x16 ? d : {32'h0, d[31:0]};
    ec = {crc_of(vec_of(d[63:32], mg[7:4], hi)),
          crc_of(vec_of(d[31:0], mg[3:0], hi))};
    if (!x16) begin
      ec[15:8] = 8'h00;
      mg[7:4] = 4'h0;
    end
    k = 0;
    while (req_rdy !== 1'b1 && k < 40) begin
      @(negedge core_clk);
      k++;
    end
    @(posedge core_clk);
    cfg_x16 <= x16;
    cfg_dmi_en <= en;
    req_a2 <= hi;
    req_bad_crc <= bad;
    req_data <= d;
    req_dmi <= m;
    req_vld <= 1'b1;
    ce <= !frz;
    if (frz) begin
      repeat (3) @(negedge core_clk);
      check(req_rdy, 64'h1, "frozen host took request");
      check(bcw_link_if_inst.beat_vld, 64'h0, "frozen beat");
      @(posedge core_clk);
      ce <= 1'b1;
    end
    @(posedge core_clk);
    req_vld <= 1'b0;
    k = 0;
    while (wr_vld !== 1'b1 && k < 30) begin
      @(negedge core_clk);
      k++;
    end
    check(wr_vld, 64'h1, "no write seen");
    check(wr_data, ed, "data");
    check(wr_dmi, mg, "mask beats");
    check(wr_a2, hi, "a2");
    check(calc_crc, ec, "computed crc");
    check(wr_crc_err, bad, "crc flag");
    check(wr_err_tree, {1'b0, bad}, "tree flag");
    check(wr_fmt_err, 64'h0, "format flag");
  endtask

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // Whole run needs well under 300 cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 1000) begin
      n_errors++;
      $display("wrong value at %0t: timeout", $time);
      end_of_test();
    end
  end

  initial begin
    reset = 1'b1;
    {cfg_x16, cfg_dmi_en, req_vld, req_a2, req_bad_crc} = 5'h0;
    ce = 1'b1;
    req_data = 64'h0;
    req_dmi = 8'h0;
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    // Every width, a2 and mask setting, then two corrupted crc beats
    // The last request first waits out three frozen cycles
    for (int i = 0; i < 10; i++) begin
      run_write(i[2] | (i[3] & i[0]), i[1], i[0], i[3], i == 9,
        64'h0123456789ABCDEF ^ {16{i[3:0]}}, 8'h5A ^ {2{i[3:0]}});
      $display("test %0d done", i);
    end
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
